// ---- pkg/board_status_params.svh ----
// Purpose: Offsets, bit positions, reset values and codes of the board register bank
// Assumes: Word-aligned registers, byte address is four times the register index
// Notes:   Definitions only
`ifndef BOARD_STATUS_PARAMS_SVH
`define BOARD_STATUS_PARAMS_SVH

// ==========================================================
// Register indices and byte addresses
`define BOOT_STATUS_IDX 32'h0000_820a
`define TWO_WIRE_IDX 32'h0000_820b
`define SWITCH_IDX 32'h0000_820c
`define BOOT_STATUS_ADDR (`BOOT_STATUS_IDX * 32'h0000_0004)
`define TWO_WIRE_ADDR (`TWO_WIRE_IDX * 32'h0000_0004)
`define SWITCH_ADDR (`SWITCH_IDX * 32'h0000_0004)

// ==========================================================
// Two-wire register field positions
`define TW_CLK_DRIVE_BIT 7
`define TW_DATA_DRIVE_BIT 6
`define TW_CLK_SENSE_BIT 5
`define TW_DATA_SENSE_BIT 4
`define TW_FILL_BITS 4'hf

// ==========================================================
// Reset values and boot codes
`define BOOT_STATUS_RST 2'h3
`define TWO_WIRE_RST 8'hff
`define BOOT_MODE_BACKUP 2'h2
`define BOOT_MODE_NORMAL 2'h3

`endif

// ---- pkg/board_status_pkg.sv ----
// Purpose: Types shared by the board register bank
// Assumes: Nothing beyond the params header
// Notes:   Types only; numbers live in the header
`default_nettype none

package board_status_pkg;
   // ==========================================================
   // Bus data phase kinds
   typedef enum logic [1:0] {PH_IDLE, PH_READ, PH_WRITE} phase_t;
   // Register selected by an address phase
   typedef enum logic [1:0] {SEL_NONE, SEL_BOOT, SEL_WIRE, SEL_SWITCH} reg_sel_t;
endpackage : board_status_pkg

`default_nettype wire

// ---- pkg/two_wire_if.sv ----
// Purpose: Carrier between register decode and the two-wire port logic
// Assumes: Single clock domain
// Notes:   Write strobe is one cycle wide
`timescale 1ns/10ps
`default_nettype none

interface two_wire_if;
   logic wr_en; // One-cycle write strobe
   logic clk_drive_wr; // Written clock latch level
   logic data_drive_wr; // Written data latch level
   logic clk_level; // Clock line as seen now
   logic data_level; // Data line as seen now
   // Register side
   modport regs (output wr_en, output clk_drive_wr, output data_drive_wr,
                 input clk_level, input data_level);
   // Pin side
   modport port (input wr_en, input clk_drive_wr, input data_drive_wr,
                 output clk_level, output data_level);
endinterface : two_wire_if

`default_nettype wire

// ---- rtl/two_wire_port.sv ----
// Purpose: Open-collector clock and data latches for the bit-banged two-wire bus
// Assumes: Line inputs are synchronous to hclk
// Notes:   Pins are only ever pulled low or released
`timescale 1ns/10ps
`default_nettype none
`include "board_status_params.svh"

module two_wire_port (
   input wire logic hclk,
   input wire logic hresetn,
   two_wire_if.port tw,
   input wire logic wire_clock_in,
   output logic wire_clock_out,
   output logic wire_clock_oe,
   input wire logic wire_data_in,
   output logic wire_data_out,
   output logic wire_data_oe
);
   logic clk_latch_reg; // Clock output latch
   logic data_latch_reg; // Data output latch
   localparam logic [7:0] RELEASE_ALL = `TWO_WIRE_RST; // Register reset image, both lines released

   // ==========================================================
   // Latches
   // reset releases lines
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clk_latch_reg <= RELEASE_ALL[`TW_CLK_DRIVE_BIT];
         data_latch_reg <= RELEASE_ALL[`TW_DATA_DRIVE_BIT];
      end else if (tw.wr_en) begin
         clk_latch_reg <= tw.clk_drive_wr;
         data_latch_reg <= tw.data_drive_wr;
      end
   end

   // ==========================================================
   // Open-collector drive: low when latch is 0, released otherwise
   // open collector drive
   assign wire_clock_out = 1'b0;
   assign wire_data_out = 1'b0;
   assign wire_clock_oe = ~clk_latch_reg;
   assign wire_data_oe = ~data_latch_reg;
   // Line levels go straight back; the bus mirrors the real wire
   assign tw.clk_level = wire_clock_in;
   assign tw.data_level = wire_data_in;

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_clk_latch_write: assert property (tw.wr_en |=> wire_clock_oe == !$past(tw.clk_drive_wr))
      else $error("Clock latch did not follow write");
   a_data_latch_write: assert property (tw.wr_en |=> wire_data_oe == !$past(tw.data_drive_wr))
      else $error("Data latch did not follow write");
   a_lines_hold: assert property (!tw.wr_en |=> $stable(wire_clock_oe) && $stable(wire_data_oe))
      else $error("Line drive changed without a write");
   a_reset_release: assert property ($rose(hresetn) |-> !wire_clock_oe && !wire_data_oe)
      else $error("Lines not released after reset");
endmodule : two_wire_port

`default_nettype wire

// ---- rtl/boot_mode_sense.sv ----
// Purpose: Samples the boot-select inputs and decodes the boot mode
// Assumes: Inputs are synchronous to hclk
// Notes:   Decoded flags are registered alongside the sample
`timescale 1ns/10ps
`default_nettype none
`include "board_status_params.svh"

module boot_mode_sense (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [1:0] boot_select_inputs,
   output logic [1:0] boot_bits,
   output logic boot_from_backup,
   output logic boot_normal,
   output logic boot_reserved
);
   // ==========================================================
   // Sample and decode
   // reset value three
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         boot_bits <= `BOOT_STATUS_RST;
         boot_from_backup <= 1'b0;
         boot_normal <= 1'b1;
         boot_reserved <= 1'b0;
      end else begin
         boot_bits <= boot_select_inputs;
         boot_from_backup <= (boot_select_inputs == `BOOT_MODE_BACKUP);
         boot_normal <= (boot_select_inputs == `BOOT_MODE_NORMAL);
         boot_reserved <= ~boot_select_inputs[1];
      end
   end

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_boot_reset: assert property ($rose(hresetn) |-> boot_bits == 2'h3)
      else $error("Boot bits not three after reset");
   a_boot_follow: assert property (hresetn |=> boot_bits == $past(boot_select_inputs))
      else $error("Boot bits do not follow inputs");
   a_boot_decode: assert property (
      boot_from_backup == (boot_bits == 2'h2) && boot_normal == (boot_bits == 2'h3))
      else $error("Boot mode decode wrong");
   a_boot_onehot: assert property ($onehot({boot_from_backup, boot_normal, boot_reserved}))
      else $error("Boot mode flags not one-hot");
endmodule : boot_mode_sense

`default_nettype wire

// ---- rtl/board_status_regs.sv ----
// Purpose: AHB-Lite register bank with boot status, two-wire bit-bang and switch inputs
// Assumes: Single 40 MHz clock; all pins synchronous to hclk
// Notes:   Zero wait states, always OKAY; unmapped reads give zero
//
// Overview of operation
// - Boot status shows boot inputs, resets 0x03
// - Boot code two backup, three normal
// - Clock drive bit writes latch, reads line
// - Data drive bit writes latch, reads line
// - Latches pull low or release lines
// - Clock sense bit reports clock line
// - Data sense bit reports data line
// - Reserved bits written one; reset all ones
// - Switch register shows four contacts, upper zero
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "board_status_params.svh"

module board_status_regs
   import board_status_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Board inputs
   input wire logic [1:0] boot_select_inputs,
   input wire logic [3:0] config_switch,
   // Decoded boot mode
   output logic boot_from_backup,
   output logic boot_normal,
   output logic boot_reserved,
   // Two-wire lines, open collector
   input wire logic wire_clock_in,
   output logic wire_clock_out,
   output logic wire_clock_oe,
   input wire logic wire_data_in,
   output logic wire_data_out,
   output logic wire_data_oe
);

   // ==========================================================
   // Declarations
   phase_t phase_reg; // Kind of the pending data phase
   reg_sel_t sel_reg; // Register addressed by the pending phase
   logic [31:0] hrdata_reg; // Read data, loaded at address phase
   logic [1:0] boot_bits; // Sampled boot inputs
   logic [3:0] switch_reg; // Sampled switch contacts
   logic addr_accept; // Address phase taken this edge
   reg_sel_t addr_sel; // Decode of the current address
   two_wire_if tw (); // Carrier to the pin logic

   // ==========================================================
   // Decode and read functions
   // Map a byte address onto a register; anything else selects nothing
   // A full compare costs a little logic but keeps aliases out of the map,
   // so a stray address can never reach the latches
   function automatic reg_sel_t decode_addr(input logic [31:0] a);
      reg_sel_t s;
      s = SEL_NONE;
      if (a == `BOOT_STATUS_ADDR) begin
         s = SEL_BOOT;
      end else if (a == `TWO_WIRE_ADDR) begin
         s = SEL_WIRE;
      end else if (a == `SWITCH_ADDR) begin
         s = SEL_SWITCH;
      end
      return s;
   endfunction : decode_addr

   // Byte returned for a selected register
   function automatic logic [7:0] read_value(input reg_sel_t s, input logic [1:0] boot,
                                            input logic ck, input logic dt,
                                            input logic [3:0] sw);
      logic [7:0] v;
      v = 8'h00;
      case (s)
         SEL_BOOT: begin
            v = {6'h00, boot};
         end
         SEL_WIRE: begin
            v[`TW_CLK_DRIVE_BIT] = ck;
            v[`TW_DATA_DRIVE_BIT] = dt;
            v[`TW_CLK_SENSE_BIT] = ck;
            v[`TW_DATA_SENSE_BIT] = dt;
            v[3:0] = `TW_FILL_BITS;
         end
         SEL_SWITCH: begin
            v = {4'h0, sw};
         end
         default: begin
            v = 8'h00;
         end
      endcase
      return v;
   endfunction : read_value

   // ==========================================================
   // Address phase
   // A transfer is taken when selected, NONSEQ or SEQ, and the bus is ready
   // Only htrans[1] counts: IDLE and BUSY leave the bank alone, and a
   // single-transfer master never issues SEQ anyway
   assign addr_accept = hsel && htrans[1] && hready;
   assign addr_sel = decode_addr(haddr);

   // Zero wait states: every phase completes in one cycle
   // Trade-off: a slower register could not be added here without
   // first building a wait-state path
   assign hreadyout = 1'b1;
   // No error case exists; unmapped space reads zero and drops writes
   assign hresp = 1'b0;
   assign hrdata = hrdata_reg;

   // ==========================================================
   // Data phase tracker
   // Remembers what the address phase asked for, so the write strobe
   // lines up with hwdata, which only stands one cycle later
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase_reg <= PH_IDLE;
         sel_reg <= SEL_NONE;
      end else if (hready) begin
         // Phase moves on only when the bus completes
         if (addr_accept) begin
            phase_reg <= hwrite ? PH_WRITE : PH_READ;
            sel_reg <= addr_sel;
         end else begin
            // Nothing taken: no data phase is pending
            phase_reg <= PH_IDLE;
            sel_reg <= SEL_NONE;
         end
      end
   end

   // ==========================================================
   // Read data
   // Loaded at the address edge so it stands in the data phase from a flop;
   // it then holds until the next read, which keeps the bus quiet
   // Lines are sampled at the address edge, a cycle earlier than the data
   // edge; software bit-banging moves them far slower than that
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_reg <= 32'h0000_0000;
      end else if (addr_accept && !hwrite) begin
         // Line levels come back through the carrier, as the pin logic sees them
         hrdata_reg <= {24'h00_0000, read_value(addr_sel, boot_bits, tw.clk_level,
                                                tw.data_level, switch_reg)};
      end
   end

   // ==========================================================
   // Write strobe into the two-wire latches
   // Only the two-wire register takes writes; hsize is not checked, the
   // low byte lane carries the register byte for word transfers
   // The strobe is combinational so the latch takes hwdata at the edge that
   // ends the data phase; a registered strobe would need hwdata held longer
   always_comb begin
      tw.wr_en = 1'b0;
      tw.clk_drive_wr = hwdata[`TW_CLK_DRIVE_BIT];
      tw.data_drive_wr = hwdata[`TW_DATA_DRIVE_BIT];
      case (phase_reg)
         PH_WRITE: begin
            tw.wr_en = (sel_reg == SEL_WIRE);
         end
         PH_READ: begin
            tw.wr_en = 1'b0;
         end
         default: begin
            tw.wr_en = 1'b0;
         end
      endcase
   end

   // ==========================================================
   // Switch contacts
   // No reset on purpose: the register has no defined reset value and
   // simply tracks the contacts one cycle late
   // Limitation: the first cycle after power-up reads an unknown value
   // One flop is enough: contacts move by hand and never race the bus
   // switch sampling
   always_ff @(posedge hclk) begin
      switch_reg <= config_switch;
   end

   // ==========================================================
   // Sub-blocks
   // Boot inputs are sampled in their own block so the decoded flags and
   // the readable bits always come from the same flop stage
   boot_mode_sense u_boot (
      .hclk(hclk),
      .hresetn(hresetn),
      .boot_select_inputs(boot_select_inputs),
      .boot_bits(boot_bits),
      .boot_from_backup(boot_from_backup),
      .boot_normal(boot_normal),
      .boot_reserved(boot_reserved)
   );

   // Pin logic; bits 3..0 written by software are not stored anywhere
   two_wire_port u_wire (
      .hclk(hclk),
      .hresetn(hresetn),
      .tw(tw.port),
      .wire_clock_in(wire_clock_in),
      .wire_clock_out(wire_clock_out),
      .wire_clock_oe(wire_clock_oe),
      .wire_data_in(wire_data_in),
      .wire_data_out(wire_data_out),
      .wire_data_oe(wire_data_oe)
   );

   // ==========================================================
   // Checks
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // Every check is in the hclk domain and rests while reset is low
   // ==========================================================
   // Read data one edge after the address phase, plus write path and reset release
   a_boot_read: assert property (
      addr_accept && !hwrite && addr_sel == SEL_BOOT |=> hrdata == {30'h0, $past(boot_bits)})
      else $error("Boot status read wrong");
   a_boot_nowrite: assert property (phase_reg == PH_WRITE && sel_reg == SEL_BOOT |-> !tw.wr_en)
      else $error("Boot status write reached latches");
   a_clk_readback: assert property (
      addr_accept && !hwrite && addr_sel == SEL_WIRE |=> hrdata[7] == $past(wire_clock_in))
      else $error("Clock drive bit does not read the line");
   a_data_readback: assert property (
      addr_accept && !hwrite && addr_sel == SEL_WIRE |=> hrdata[6] == $past(wire_data_in))
      else $error("Data drive bit does not read the line");
   a_clk_sense: assert property (
      addr_accept && !hwrite && addr_sel == SEL_WIRE |=> hrdata[5] == $past(wire_clock_in))
      else $error("Clock sense bit wrong");
   a_data_sense: assert property (
      addr_accept && !hwrite && addr_sel == SEL_WIRE |=> hrdata[4] == $past(wire_data_in))
      else $error("Data sense bit wrong");
   a_wire_fill: assert property (
      addr_accept && !hwrite && addr_sel == SEL_WIRE |=> hrdata[31:8] == 24'h0 && hrdata[3:0] == 4'hf)
      else $error("Two-wire filler bits wrong");
   a_wire_write: assert property (
      addr_accept && hwrite && addr_sel == SEL_WIRE ##1 hready |-> tw.wr_en ##1 wire_clock_oe == !$past(hwdata[7]))
      else $error("Two-wire write did not reach the line");
   a_switch_read: assert property (
      addr_accept && !hwrite && addr_sel == SEL_SWITCH |=> hrdata == {28'h0, $past(config_switch, 2)})
      else $error("Switch read wrong");
   a_unmapped_zero: assert property (addr_accept && !hwrite && addr_sel == SEL_NONE |=> hrdata == 32'h0)
      else $error("Unmapped read not zero");
   a_reset_lines: assert property ($rose(hresetn) |-> !wire_clock_oe && !wire_data_oe)
      else $error("Lines driven after reset");

   // ==========================================================
   // Decode, write path and carrier
   // backup code flag
   a_flag_backup: assert property (boot_bits == 2'h2 |-> boot_from_backup && !boot_normal)
      else $error("Backup boot flag wrong");
   a_flag_normal: assert property (boot_bits == 2'h3 |-> boot_normal && !boot_from_backup)
      else $error("Normal boot flag wrong");
   a_flag_reserved: assert property (!boot_bits[1] |-> boot_reserved && !boot_normal)
      else $error("Reserved boot flag wrong");
   a_data_write: assert property (
      addr_accept && hwrite && addr_sel == SEL_WIRE ##1 hready |-> tw.wr_en ##1 wire_data_oe == !$past(hwdata[6]))
      else $error("Two-wire write did not reach the data line");
   a_pull_only: assert property (!wire_clock_out && !wire_data_out)
      else $error("Two-wire line driven high");
   a_switch_nowrite: assert property (phase_reg == PH_WRITE && sel_reg != SEL_WIRE |-> !tw.wr_en)
      else $error("Write outside the two-wire register reached latches");
   a_line_carrier: assert property (tw.clk_level == wire_clock_in && tw.data_level == wire_data_in)
      else $error("Line levels lost on the carrier");
   a_read_holds: assert property (!(addr_accept && !hwrite) |=> $stable(hrdata))
      else $error("Read data moved without a read");
   a_write_okay: assert property (phase_reg == PH_WRITE |-> hreadyout && !hresp)
      else $error("Write not answered OKAY");
   a_write_phase: assert property (addr_accept && hwrite |=> phase_reg == PH_WRITE)
      else $error("Write address phase not tracked");
   a_read_nowrite: assert property (phase_reg == PH_READ |-> !tw.wr_en)
      else $error("Read moved a line latch");

endmodule : board_status_regs

`default_nettype wire

// ---- dv/temp_sensor_model.sv ----
// Purpose: Behavioural temperature sensor on the bit-banged two-wire bus
// Assumes: Bench resolves each line from every party's pull-down
// Notes:   Acknowledges the eighth bit after a start; bench may hold lines low
`timescale 1ns/10ps
`default_nettype none

module temp_sensor_model (
   input wire logic scl,
   input wire logic sda,
   input wire logic hold_clk,
   input wire logic hold_data,
   output logic clk_pull,
   output logic data_pull
);
   // ==========================================================
   // Frame tracking
   logic active = 1'b0; // Inside a frame
   int bit_cnt = 0; // Clock rises since the start
   logic ack = 1'b0; // Acknowledge pull-down

   // Data moving while clock is high is a start or a stop
   always @(sda) begin
      if (scl === 1'b1) begin
         active = (sda === 1'b0);
         bit_cnt = 0;
         ack = 1'b0;
      end
   end

   // Count bit clocks inside a frame
   always @(posedge scl) begin
      if (active) begin
         bit_cnt = bit_cnt + 1;
      end
   end

   // Acknowledge spans the ninth clock, then the next byte starts
   always @(negedge scl) begin
      if (active && bit_cnt == 8) begin
         ack = 1'b1;
      end else if (bit_cnt == 9) begin
         ack = 1'b0;
         bit_cnt = 0;
      end
   end

   assign clk_pull = hold_clk;
   assign data_pull = hold_data | ack;
endmodule : temp_sensor_model

`default_nettype wire

// ---- dv/board_status_i2c_switch_regs_tb.sv ----
// Purpose: Self-checking bench for the board register bank
// Assumes: Zero-wait AHB-Lite slave; lines pulled up unless someone pulls low
// Notes:   Latch changes are given two cycles to reach the pins
`timescale 1ns/10ps
`default_nettype none
`include "board_status_params.svh"

module board_status_i2c_switch_regs_tb;
   // ==========================================================
   // Signals
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] boot_select_inputs = 2'h0;
   logic [3:0] config_switch = 4'h0;
   logic hold_clk = 1'b0; // Sensor holds clock low
   logic hold_data = 1'b0; // Sensor holds data low
   wire hready, hresp, boot_from_backup, boot_normal, boot_reserved;
   wire [31:0] hrdata;
   wire wire_clock_out, wire_clock_oe, wire_data_out, wire_data_oe, clk_pull, data_pull;
   wire wire_clock_in, wire_data_in;
   int bad_count = 0;
   int n_checks = 0;
   logic [31:0] seed = 32'hd2d28349; // Fixed seed keeps runs repeatable

   // Pull-ups win unless some party pulls low
   assign wire_clock_in = ~(wire_clock_oe | clk_pull);
   assign wire_data_in = ~(wire_data_oe | data_pull);

   initial begin
      forever #12.5 hclk = ~hclk;
   end

   // ==========================================================
   // Instances
   board_status_regs i_board_status_regs (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .boot_select_inputs(boot_select_inputs),
      .config_switch(config_switch), .boot_from_backup(boot_from_backup), .boot_normal(boot_normal),
      .boot_reserved(boot_reserved), .wire_clock_in(wire_clock_in), .wire_clock_out(wire_clock_out),
      .wire_clock_oe(wire_clock_oe), .wire_data_in(wire_data_in), .wire_data_out(wire_data_out),
      .wire_data_oe(wire_data_oe));
   temp_sensor_model i_temp_sensor_model (.scl(wire_clock_in), .sda(wire_data_in), .hold_clk(hold_clk),
      .hold_data(hold_data), .clk_pull(clk_pull), .data_pull(data_pull));

   // ==========================================================
   // Helpers
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction : xs

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : close_out

   // Bounded wait for hready sampled high at a rising edge
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 16);
      if (hready !== 1'b1) begin
         bad_count++;
         close_out();
      end
   endtask : wait_ready

   // One single-word transfer; called just after a rising edge
   task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
      chk({31'h0, hresp}, 32'h0);
   endtask : ahb

   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] d;
      ahb(a, 1'b0, 32'h0, d);
      chk(d, exp);
   endtask : rd_chk

   // Software step on the two-wire bus, reserved bits written as ones
   task automatic wire_set(input logic c, input logic d);
      logic [31:0] d0;
      ahb(`TWO_WIRE_ADDR, 1'b1, {24'h0, c, d, 6'h3f}, d0);
      repeat (2) @(posedge hclk);
   endtask : wire_set

   // ==========================================================
   // Hang guard
   initial begin
      repeat (20000) @(posedge hclk);
      bad_count++;
      close_out();
   end

   // ==========================================================
   // Main sequence
   initial begin
      logic [31:0] r;
      logic [3:0] sw;
      logic lc;
      logic ld;
      repeat (3) @(posedge hclk);
      chk({28'h0, wire_clock_out, wire_data_out, wire_clock_oe, wire_data_oe}, 32'h0);
      chk({29'h0, boot_from_backup, boot_normal, boot_reserved}, 32'h2);
      hresetn <= 1'b1;
      rd_chk(`TWO_WIRE_ADDR, 32'hff);
      for (int i = 0; i < 4; i++) begin
         boot_select_inputs <= i[1:0];
         repeat (3) @(posedge hclk);
         chk({29'h0, boot_from_backup, boot_normal, boot_reserved}, {29'h0, i == 2, i == 3, i < 2});
         rd_chk(`BOOT_STATUS_ADDR, i);
         seed = xs(seed);
         ahb(`BOOT_STATUS_ADDR, 1'b1, seed, r);
         rd_chk(`BOOT_STATUS_ADDR, i);
      end
      for (int i = 0; i < 16; i++) begin
         seed = xs(seed);
         sw = (i < 2) ? {4{i[0]}} : seed[3:0];
         config_switch <= sw;
         repeat (2) @(posedge hclk);
         rd_chk(`SWITCH_ADDR, {28'h0, sw});
      end
      ahb(`SWITCH_ADDR + 32'h4, 1'b1, seed, r);
      rd_chk(`SWITCH_ADDR + 32'h4, 32'h0);
      for (int i = 0; i < 16; i++) begin
         hold_clk <= i[1];
         hold_data <= i[0];
         wire_set(i[3], i[2]);
         lc = i[3] & ~i[1];
         ld = i[2] & ~i[0];
         chk({28'h0, wire_clock_out, wire_data_out, wire_clock_oe, wire_data_oe}, {30'h0, ~i[3], ~i[2]});
         rd_chk(`TWO_WIRE_ADDR, {24'h0, lc, ld, lc, ld, 4'hf});
      end
      hold_clk <= 1'b0;
      hold_data <= 1'b0;
      // Software frame: start, random byte, acknowledge, stop
      seed = xs(seed);
      wire_set(1'b1, 1'b1);
      wire_set(1'b1, 1'b0);
      wire_set(1'b0, 1'b0);
      // Data moves only while clock is low, so no bit looks like a start or stop
      for (int i = 7; i >= 0; i--) begin
         wire_set(1'b0, seed[i]);
         wire_set(1'b1, seed[i]);
         wire_set(1'b0, seed[i]);
      end
      wire_set(1'b0, 1'b1);
      wire_set(1'b1, 1'b1);
      rd_chk(`TWO_WIRE_ADDR, 32'haf);
      wire_set(1'b0, 1'b1);
      rd_chk(`TWO_WIRE_ADDR, 32'h5f);
      wire_set(1'b0, 1'b0);
      wire_set(1'b1, 1'b0);
      wire_set(1'b1, 1'b1);
      rd_chk(`TWO_WIRE_ADDR, 32'hff);
      // Reset in mid-run releases both lines
      wire_set(1'b0, 1'b0);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      chk({30'h0, wire_clock_oe, wire_data_oe}, 32'h0);
      hresetn <= 1'b1;
      rd_chk(`TWO_WIRE_ADDR, 32'hff);
      close_out();
   end
endmodule : board_status_i2c_switch_regs_tb

`default_nettype wire
